// *** core/eabi_core.sv ***
// External async bus interface bus-cycle engine
`include "eabi_params.svh"
module eabi_core
   import eabi_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   rstn,
   input  wire eabi_req_t              req,
   output eabi_rsp_t                   rsp,
   output logic                        req_ready,
   output logic [`EABI_ADDR_W-1:0]     ext_address_lines,
   output logic                        address_strobe_n,
   output logic                        data_strobe_n,
   output logic                        read_write_dir,
   output logic [1:0]                  transfer_size_code,
   output logic [2:0]                  space_code,
   output logic [`EABI_DATA_W-1:0]     data_out,
   output logic                        data_oe,
   output logic                        addr_oe,
   input  wire logic [`EABI_DATA_W-1:0] data_in,
   input  wire logic [1:0]             port_ack,
   input  wire logic [1:0]             cs_port_ack,
   input  wire logic                   cs_ack_en,
   input  wire logic                   bus_fault_n,
   input  wire logic                   auto_vector_n,
   input  wire logic                   stall_request_n,
   input  wire logic                   bus_granted,
   output logic                        irq_block
);
   eabi_pins_t pins_raw, pins_s;
   logic [`EABI_DATA_W-1:0] data_s;
   logic auto_vector_n_s;

   // Pins come from another timing domain
   assign pins_raw = '{ack: port_ack, fault_n: bus_fault_n, stall_n: stall_request_n};

   eabi_sync #(.W(4), .INIT(4'hf)) u_sync_ctl (
      .clk  (clk),
      .rstn (rstn),
      .d    (pins_raw),
      .q    (pins_s)
   );

   eabi_sync #(.W(17), .INIT(17'h1ffff)) u_sync_dat (
      .clk  (clk),
      .rstn (rstn),
      .d    ({auto_vector_n, data_in}),
      .q    ({auto_vector_n_s, data_s})
   );

   typedef struct packed {
      eabi_state_t             state;
      logic                    rwd;
      logic [`EABI_ADDR_W-1:0] addr;
      logic [1:0]              size;
      logic [2:0]              space;
      logic                    write;
      logic [31:0]             wbuf;
      logic [31:0]             rbuf;
      logic                    as_n;
      logic                    ds_n;
      logic [15:0]             dout;
      logic                    doe;
      logic                    aoe;
      logic                    rdy;
      eabi_rsp_t               rsp;
      logic                    irqb;
      logic                    fin;
      logic [1:0]              step;
   } eabi_st_t;

   eabi_st_t st_r, st_nxt;
   logic [1:0] ack_eff;
   logic       ack_hit;
   logic [1:0] left;
   logic [1:0] took;
   logic [1:0] remain;
   logic [1:0] next_left;

   // Chip-select logic may stand in for the external device
   assign ack_eff = cs_ack_en ? cs_port_ack : pins_s.ack;

   assign ack_hit = (ack_eff == `EABI_ACK_8) || (ack_eff == `EABI_ACK_16);

   // Bytes still owed, from size code
   always_comb begin
      case (st_r.size)
         `EABI_SIZ_BYTE:  left = 2'h1;
         `EABI_SIZ_WORD:  left = 2'h2;
         `EABI_SIZ_THREE: left = 2'h3;
         default:         left = 2'h0;
      endcase
   end

   // Byte port moves one byte; word port up to two, never past odd address
   always_comb begin
      if (ack_eff == `EABI_ACK_8 || st_r.size == `EABI_SIZ_BYTE || st_r.addr[0]) begin
         took = 2'h1;
      end else begin
         took = 2'h2;
      end
      remain = left - took;
      next_left = left - st_r.step;
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.rsp.done  = 1'b0;
      st_nxt.rsp.fault = 1'b0;
      st_nxt.rsp.retry = 1'b0;
      case (st_r.state)
         EABI_IDLE: begin
            st_nxt.rdy = 1'b1;
            st_nxt.ds_n = 1'b1;
            st_nxt.doe = 1'b0;
            if (req.valid && st_r.rdy && pins_s.stall_n) begin
               st_nxt.rdy = 1'b0;
               st_nxt.addr = req.addr;
               st_nxt.size = req.size;
               st_nxt.space = req.space;
               st_nxt.write = req.write;
               st_nxt.rwd = ~req.write;
               st_nxt.fin = 1'b0;
               st_nxt.wbuf = req.wdata;
               st_nxt.rbuf = 32'h0;
               st_nxt.aoe = 1'b1;
               st_nxt.state = EABI_START;
            end
         end
         EABI_START: begin
            // Half clock is one core tick at twice the bus rate
            st_nxt.as_n = 1'b0;
            if (!st_r.write) begin
               st_nxt.ds_n = 1'b0;
            end
            st_nxt.state = EABI_STRB;
         end
         EABI_STRB: begin
            if (st_r.write) begin
               // Full 16 lines, MSB-first operand word
               st_nxt.dout = st_r.wbuf[31:16];
               st_nxt.doe = 1'b1;
            end
            st_nxt.state = EABI_WAIT;
         end
         EABI_WAIT: begin
            if (st_r.write && st_r.ds_n) begin
               st_nxt.ds_n = 1'b0;
            end else if (!pins_s.fault_n) begin
               // Fault with stall asks for a rerun
               st_nxt.rsp.fault = pins_s.stall_n;
               st_nxt.rsp.retry = ~pins_s.stall_n;
               // Address kept so external logic can rerun the cycle
               st_nxt.fin = 1'b1;
               st_nxt.state = EABI_DONE;
            end else if (ack_hit) begin
               if (!st_r.write) begin
                  // Last sampled data of this cycle, merged MSB first
                  if (took == 2'h1) begin
                     st_nxt.rbuf = {st_r.rbuf[23:0],
                        (st_r.addr[0] && ack_eff == `EABI_ACK_16) ? data_s[7:0] : data_s[15:8]};
                  end else begin
                     st_nxt.rbuf = {st_r.rbuf[15:0], data_s};
                  end
               end
               st_nxt.wbuf = (took == 2'h1) ? {st_r.wbuf[23:0], 8'h00} :
                                             {st_r.wbuf[15:0], 16'h0000};
               // Address and size move only once the strobe is gone
               st_nxt.step = took;
               st_nxt.fin = (remain == `EABI_SIZ_LONG);
               if (remain == `EABI_SIZ_LONG) begin
                  st_nxt.rsp.done = 1'b1;
               end
               st_nxt.state = EABI_DONE;
            end
         end
         EABI_DONE: begin
            st_nxt.as_n = 1'b1;
            st_nxt.ds_n = 1'b1;
            st_nxt.doe = 1'b0;
            if (!pins_s.stall_n) begin
               // Address, space, size, direction stay put
               st_nxt.aoe = 1'b0;
               st_nxt.irqb = 1'b1;
               st_nxt.state = EABI_STALL;
            end else if (!cs_ack_en && ack_hit) begin
               // Synchronised ack lags the pin; a stale one would end the next cycle
               st_nxt.state = EABI_DONE;
            end else if (st_r.fin) begin
               st_nxt.state = EABI_IDLE;
            end else begin
               st_nxt.addr = st_r.addr + {22'h0, st_r.step};
               st_nxt.size = next_left;
               st_nxt.state = EABI_START;
            end
         end
         EABI_STALL: begin
            // Single cycle mode: wait for stall release and bus grant
            if (bus_granted) begin
               st_nxt.aoe = 1'b1;
            end
            if (pins_s.stall_n && bus_granted) begin
               st_nxt.irqb = 1'b0;
               // Back through the gap so outputs move only after the stall ends
               st_nxt.state = EABI_DONE;
            end
         end
         default: begin
            st_nxt.state = EABI_IDLE;
         end
      endcase
      if (st_r.state == EABI_WAIT && st_nxt.state == EABI_DONE && st_nxt.rsp.done) begin
         st_nxt.rsp.rdata = st_nxt.rbuf;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= '{state: EABI_IDLE, rwd: 1'b1, addr: 24'h000000, size: 2'h0,
                   space: `EABI_FC_RESET, write: 1'b0, wbuf: 32'h0, rbuf: 32'h0,
                   as_n: 1'b1, ds_n: 1'b1, dout: 16'h0000, doe: 1'b0, aoe: 1'b0,
                   rdy: 1'b0, rsp: '0, irqb: 1'b0, fin: 1'b0, step: 2'h0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rsp                = st_r.rsp;
   assign req_ready          = st_r.rdy;
   assign ext_address_lines  = st_r.addr;
   assign address_strobe_n   = st_r.as_n;
   assign data_strobe_n      = st_r.ds_n;
   assign read_write_dir     = st_r.rwd;
   assign transfer_size_code = st_r.size;
   assign space_code         = st_r.space;
   assign data_out           = st_r.dout;
   assign data_oe            = st_r.doe;
   assign addr_oe            = st_r.aoe;
   assign irq_block          = st_r.irqb;
endmodule

// *** core/eabi_params.svh ***
// Constants and rule overview for the external async bus interface
// Overview of operation
// - 24-bit address, 16-bit data, byte/word/long transfers
// - Split operands into cycles per port width
// - Address of first byte held during strobe
// - Address strobe asserts half clock after start
// - Read data captured at last falling edge
// - Writes drive all sixteen data lines
// - Write data driven half clock after strobe
// - Read data strobe asserts with address strobe
// - Write data strobe one clock after address strobe
// - Direction changes only at cycle start when needed
// - Size code gives bytes still remaining
// - Three-bit space code valid during strobe
// - Port acknowledge ends cycle and sets width
// - Internal chip-select acknowledge also accepted
// - Bus fault ends improperly terminated cycle
// - Stall forces single cycle or retries fault
// - Stall floats data, strobes inactive, address held
// - Stalled outputs driven again on regaining bus
// - No interrupt service while stalled
// - Every cycle ends on handshake, not count
`ifndef EABI_PARAMS_SVH
`define EABI_PARAMS_SVH
`define EABI_ADDR_W     24
`define EABI_DATA_W     16
`define EABI_SIZ_BYTE   2'h1
`define EABI_SIZ_WORD   2'h2
`define EABI_SIZ_THREE  2'h3
`define EABI_SIZ_LONG   2'h0
`define EABI_ACK_WAIT   2'h3
`define EABI_ACK_8      2'h2
`define EABI_ACK_16     2'h1
`define EABI_FC_RESET   3'h5
`endif

// *** core/eabi_pkg.sv ***
// Types for the external async bus interface
package eabi_pkg;
   typedef enum logic [2:0] {
      EABI_IDLE  = 3'h0,
      EABI_START = 3'h1,
      EABI_STRB  = 3'h3,
      EABI_WAIT  = 3'h2,
      EABI_DONE  = 3'h6,
      EABI_STALL = 3'h7
   } eabi_state_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [1:0]  size;
      logic [2:0]  space;
      logic [23:0] addr;
      logic [31:0] wdata;
   } eabi_req_t;

   typedef struct packed {
      logic        done;
      logic        fault;
      logic        retry;
      logic [31:0] rdata;
   } eabi_rsp_t;

   typedef struct packed {
      logic [1:0] ack;
      logic       fault_n;
      logic       stall_n;
   } eabi_pins_t;
endpackage

// *** core/eabi_sync.sv ***
// Two-flop synchroniser for pin inputs
module eabi_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } eabi_sync_st_t;
   eabi_sync_st_t st_r, st_nxt;

   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= {INIT, INIT};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.s2;
endmodule

// *** tb/eabi_chk.sv ***
// Bus protocol checker for the bus-cycle engine
module eabi_chk (
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic [23:0] ext_address_lines,
   input wire logic        address_strobe_n,
   input wire logic        data_strobe_n,
   input wire logic        read_write_dir,
   input wire logic [1:0]  transfer_size_code,
   input wire logic [2:0]  space_code,
   input wire logic        data_oe,
   input wire logic [1:0]  port_ack,
   input wire logic        cs_ack_en,
   input wire logic        bus_fault_n,
   input wire logic        irq_block
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   sequence s_wr;
      $fell(address_strobe_n) && !read_write_dir;
   endsequence
   // Three sampled wait codes still leave the cycle open after the synchroniser
   sequence s_wait;
      (!address_strobe_n && port_ack == 2'h3 && !cs_ack_en && bus_fault_n)[*3];
   endsequence
   sequence s_ack;
      (!address_strobe_n && port_ack == 2'h1 && !cs_ack_en)[*2];
   endsequence
   a_read_ds_with: assert property ($fell(address_strobe_n) && read_write_dir |->
      $fell(data_strobe_n)) else $error("read data strobe late");
   a_write_ds_late: assert property (s_wr |-> data_strobe_n [*2] ##1 !data_strobe_n)
      else $error("write data strobe timing");
   a_write_data_half: assert property (s_wr |-> !data_oe ##1 data_oe)
      else $error("write data timing");
   a_write_drives: assert property (!read_write_dir && !data_strobe_n |-> data_oe)
      else $error("write data not driven");
   a_ctrl_held: assert property (!address_strobe_n && !$past(address_strobe_n) |->
      $stable({ext_address_lines, transfer_size_code, space_code, read_write_dir}))
      else $error("control moved under strobe");
   a_dir_at_start: assert property ($changed(read_write_dir) |-> address_strobe_n)
      else $error("direction moved mid cycle");
   a_stall_quiet: assert property (irq_block |-> address_strobe_n && data_strobe_n && !data_oe)
      else $error("bus active while stalled");
   a_stall_held: assert property ($past(irq_block) |->
      $stable({ext_address_lines, transfer_size_code, space_code, read_write_dir}))
      else $error("control lost during stall");
   a_ack_waits: assert property (s_wait |=> !address_strobe_n)
      else $error("cycle ended on wait code");
   a_ack_ends: assert property (s_ack |-> ##[1:4] address_strobe_n)
      else $error("cycle not ended by ack");
endmodule
bind eabi_core eabi_chk i_eabi_chk (.clk, .rstn, .ext_address_lines, .address_strobe_n,
   .data_strobe_n, .read_write_dir, .transfer_size_code, .space_code, .data_oe, .port_ack,
   .cs_ack_en, .bus_fault_n, .irq_block);

// *** tb/eabi_mem.sv ***
// Behavioural memory on the far side of the bus
module eabi_mem (
   input  wire logic        clk,
   input  wire logic        address_strobe_n,
   input  wire logic        data_strobe_n,
   input  wire logic        read_write_dir,
   input  wire logic [1:0]  transfer_size_code,
   input  wire logic [23:0] ext_address_lines,
   input  wire logic [15:0] data_out,
   input  wire logic        ack_en,
   input  wire logic        wide,
   output logic      [15:0] data_in,
   output logic      [1:0]  port_ack
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] mem [256];
   logic [7:0] cnt = 8'h00;
   logic [7:0] a;
   assign a = ext_address_lines[7:0];
   initial port_ack = 2'h3;
   initial data_in = 16'h5a5a;
   // Undriven lines toggle so a stale value never reads as good data
   always @(posedge clk) begin
      if (address_strobe_n) begin
         port_ack <= 2'h3;
         cnt <= 8'h00;
         data_in <= ~data_in;
      end else if (port_ack == 2'h3) begin
         data_in <= ~data_in;
         if (ack_en && !data_strobe_n && cnt < (wide ? 8'h00 : 8'h03)) cnt <= cnt + 8'h01;
         else if (ack_en && !data_strobe_n) begin
            port_ack <= wide ? 2'h1 : 2'h2;
            if (read_write_dir) data_in <= wide ? {mem[a & 8'hfe], mem[a | 8'h01]} :
               {mem[a], ~mem[a]};
            if (!read_write_dir && !(wide && transfer_size_code == 2'h1 && a[0]))
               mem[a] <= data_out[15:8];
            if (!read_write_dir && wide && (transfer_size_code != 2'h1 || a[0]))
               mem[a | 8'h01] <= data_out[7:0];
         end
      end
   end
endmodule

// *** tb/external_async_bus_interface_tb.sv ***
// Self-checking bench for the bus-cycle engine
module external_async_bus_interface_tb
   import eabi_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk = 0, rstn = 0, cs_ack_en = 0, bus_fault_n = 1, stall_request_n = 1;
   logic        bus_granted = 1, ack_en = 1, wide = 1, as_q, req_ready, address_strobe_n;
   logic        data_strobe_n, read_write_dir, data_oe, addr_oe, irq_block;
   logic [1:0]  transfer_size_code, port_ack, cs_port_ack = 2'h3;
   logic [2:0]  space_code;
   logic [7:0]  sz_hist;
   logic [15:0] data_out, data_in;
   logic [23:0] ext_address_lines;
   eabi_req_t   req = '0;
   eabi_rsp_t   rsp, r;
   int          failures = 0, total_checks = 0;
   always #12.5 clk = ~clk;
   eabi_core i_eabi_core (.clk, .rstn, .req, .rsp, .req_ready, .ext_address_lines,
      .address_strobe_n, .data_strobe_n, .read_write_dir, .transfer_size_code, .space_code,
      .data_out, .data_oe, .addr_oe, .data_in, .port_ack, .cs_port_ack, .cs_ack_en,
      .bus_fault_n, .auto_vector_n(1'b1), .stall_request_n, .bus_granted, .irq_block);
   eabi_mem i_eabi_mem (.clk, .address_strobe_n, .data_strobe_n, .read_write_dir,
      .transfer_size_code, .ext_address_lines, .data_out, .ack_en, .wide, .data_in, .port_ack);
   always @(posedge clk) begin
      as_q <= address_strobe_n;
      if (as_q && !address_strobe_n) sz_hist <= {sz_hist[5:0], transfer_size_code};
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic op(input logic w, input logic [1:0] sz, input logic [2:0] sp,
                     input logic [23:0] a, input logic [31:0] d);
      int n;
      n = 0;
      while (req_ready !== 1'b1 && n < 100) begin
         tick(1);
         n++;
      end
      req = '{1'b1, w, sz, sp, a, d};
      sz_hist = 8'h00;
      tick(1);
      req.valid = 1'b0;
      n = 0;
      while (rsp.done !== 1'b1 && rsp.fault !== 1'b1 && rsp.retry !== 1'b1 && n < 400) begin
         tick(1);
         n++;
      end
      r = rsp;
      chk("response wait", 0, {31'h0, n == 400});
   endtask
   task automatic t_long;
      wide = 0;
      op(1'b1, 2'h0, 3'h1, 24'h000020, 32'h12345678);
      chk("byte port sizes", 8'h39, sz_hist);
      wide = 1;
      op(1'b0, 2'h0, 3'h1, 24'h000020, 32'h0);
      chk("long rdata", 32'h12345678, r.rdata);
      chk("word port sizes", 8'h02, sz_hist);
      op(1'b0, 2'h1, 3'h1, 24'h000023, 32'h0);
      chk("odd byte", 32'h78, r.rdata);
   endtask
   task automatic t_space;
      logic [2:0] codes [5] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
      foreach (codes[i]) begin
         op(1'b0, 2'h1, codes[i], 24'h000021, 32'h0);
         chk("space", codes[i], space_code);
      end
   endtask
   task automatic t_cs;
      ack_en = 0;
      cs_ack_en = 1;
      cs_port_ack = 2'h1;
      op(1'b1, 2'h2, 3'h1, 24'h000050, 32'hbeef0000);
      chk("chip-select done", 1, r.done);
      ack_en = 1;
      cs_ack_en = 0;
      cs_port_ack = 2'h3;
   endtask
   // Device never answers, so only the fault line can end the cycle
   task automatic t_fault(input logic stall);
      ack_en = 0;
      fork
         op(1'b0, 2'h2, 3'h5, 24'h000040, 32'h0);
         begin
            wait (address_strobe_n === 1'b0);
            tick(3);
            bus_fault_n = 0;
            stall_request_n = !stall;
         end
      join
      chk("fault", {31'h0, !stall}, r.fault);
      chk("retry", {31'h0, stall}, r.retry);
      bus_fault_n = 1;
      stall_request_n = 1;
      ack_en = 1;
      tick(6);
   endtask
   task automatic t_stall;
      fork
         op(1'b0, 2'h2, 3'h2, 24'h000030, 32'h0);
         begin
            wait (address_strobe_n === 1'b0);
            #2;
            stall_request_n = 0;
            bus_granted = 0;
         end
      join
      tick(3);
      chk("stall outputs", 4'hc, {irq_block, address_strobe_n, data_oe, addr_oe});
      chk("stall address", 24'h000030, ext_address_lines);
      stall_request_n = 1;
      tick(6);
      chk("stall held", 2'h2, {irq_block, addr_oe});
      bus_granted = 1;
      tick(6);
      chk("stall left", 2'h1, {irq_block, addr_oe});
   endtask
   task automatic give_verdict;
      if (failures == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      tick(4);
      rstn = 1;
      t_long();
      t_space();
      t_cs();
      t_fault(1'b0);
      t_fault(1'b1);
      t_stall();
      give_verdict();
   end
   initial begin
      #200000;
      failures++;
      give_verdict();
   end
endmodule
